// File: src/fcct_pkg.sv
package fcct_pkg;

    // ****************************************************************
    // Register map, one aligned 32-bit word per register.
    // ****************************************************************
    localparam logic [7:0] MODE_OFF = 8'h00;
    localparam logic [7:0] CTRL_OFF = 8'h04;
    localparam logic [7:0] IOSEL_OFF = 8'h08;
    localparam logic [7:0] STAT_OFF = 8'h0c;
    localparam logic [7:0] MASK_OFF = 8'h10;
    localparam logic [7:0] COUNT_OFF = 8'h14;
    localparam logic [7:0] GRA_OFF = 8'h18;
    localparam logic [7:0] GRB_OFF = 8'h1c;
    localparam logic [7:0] GRC_OFF = 8'h20;
    localparam logic [7:0] GRD_OFF = 8'h24;

    // ****************************************************************
    // Mode register fields and reset values.
    // ****************************************************************
    localparam int MODE_RUN_BIT = 7;
    localparam int MODE_BUFB_BIT = 5;
    localparam int MODE_BUFA_BIT = 4;
    localparam logic [7:0] MODE_RSVD_ONES = 8'h48;
    localparam logic [7:0] MODE_WR_MASK = 8'hb7;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] IOSEL_RESET = 16'h0000;
    localparam logic [15:0] GR_RESET = 16'hffff;

    // Control register: bit 7 clear on match A, bits 6:4 clock, 3:0 init.
    localparam int CTRL_CLR_BIT = 7;
    localparam int CTRL_CKS_LSB = 4;

    // Status bits 3:0 channel A..D events, bit 4 overflow.
    localparam int OVF_BIT = 4;
    localparam int NUM_CH = 4;

    // Counter clock divide ratios.
    localparam logic [2:0] CKS_DIV1 = 3'h0;
    localparam logic [2:0] CKS_DIV2 = 3'h1;
    localparam logic [2:0] CKS_DIV4 = 3'h2;
    localparam logic [2:0] CKS_DIV8 = 3'h3;

    // Per-channel compare action / capture edge codes (I/O select nibble).
    typedef enum logic [1:0] {
        FCCT_OUT_HOLD = 2'b00,
        FCCT_OUT_LOW = 2'b01,
        FCCT_OUT_HIGH = 2'b10,
        FCCT_OUT_TOGGLE = 2'b11
    } fcct_action_type;

    typedef struct packed {
        logic [NUM_CH-1:0] pin_in;
        logic [NUM_CH-1:0] pin_out;
        logic [NUM_CH-1:0] pin_oe;
    } fcct_pins_type;

endpackage : fcct_pkg

// File: src/fcct_timer.sv
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/10ps
module fcct_timer
    import fcct_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic event_clock_in,
    input wire logic [3:0] chan_pin_in,
    output logic [3:0] chan_pin_out,
    output logic [3:0] chan_pin_oe_out,
    output logic irq_out
);

    // ****************************************************************
    // State.
    // ****************************************************************
    logic [7:0] mode_r;
    logic [15:0] ctrl_r;
    logic [15:0] iosel_r;
    logic [4:0] stat_r;
    logic [4:0] mask_r;
    logic [15:0] count_value_r;
    logic [15:0] gr_r [NUM_CH];
    logic [3:0] pin_r;
    logic [3:0] oe_r;
    logic [3:0] cap_s1_r, cap_s2_r, cap_s3_r;
    logic ev_s1_r, ev_s2_r, ev_s3_r;
    logic [2:0] div_r;
    logic irq_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // Decoded controls.
    logic run, bufa, bufb, clr_on_a, tick, wr_en, rd_en;
    logic [2:0] cks;
    logic [3:0] pwm_sel, match, cap_rise, cap_fall, cap_ev, chan_ev;
    logic ovf_ev;

    // Mode and control fields are decoded once here. A write lands only in
    // the access phase with ready high, so a transfer never writes twice.
    // A read is latched in the setup phase and held until the master
    // takes it in the access phase.
    assign run = mode_r[MODE_RUN_BIT];
    assign bufa = mode_r[MODE_BUFA_BIT];
    assign bufb = mode_r[MODE_BUFB_BIT];
    assign pwm_sel = {mode_r[2:0], 1'b0};
    assign clr_on_a = ctrl_r[CTRL_CLR_BIT];
    assign cks = ctrl_r[CTRL_CKS_LSB +: 3];
    assign wr_en = psel_in && penable_in && pwrite_in && pready_r;
    assign rd_en = psel_in && !penable_in && !pwrite_in;

    // Capture is selected when the upper bit of a channel's nibble is set.
    // The same test sets the pin direction and gates compare matches.
    function automatic logic is_capture(input logic [15:0] sel, input int ch);
        is_capture = sel[ch*4+3];
    endfunction : is_capture

    // ****************************************************************
    // Synchronisers: pins are sampled twice before edge detection.
    // ****************************************************************
    // Both the capture pins and the event input are asynchronous. Stage
    // one feeds only stage two; stage three is the delayed copy that edge
    // detection compares against.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cap_s1_r <= 4'h0;
            cap_s2_r <= 4'h0;
            cap_s3_r <= 4'h0;
            ev_s1_r <= 1'b0;
            ev_s2_r <= 1'b0;
            ev_s3_r <= 1'b0;
        end else begin
            cap_s1_r <= chan_pin_in;
            cap_s2_r <= cap_s1_r;
            cap_s3_r <= cap_s2_r;
            ev_s1_r <= event_clock_in;
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
        end
    end
    assign cap_rise = cap_s2_r & ~cap_s3_r;
    assign cap_fall = ~cap_s2_r & cap_s3_r;

    // ****************************************************************
    // Prescaler and count enable.
    // ****************************************************************
    // Free-running divider so ratio changes take effect without reset.
    // A ratio change may shorten or stretch the first period after it.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_r <= 3'h0;
        end else begin
            div_r <= div_r + 3'h1;
        end
    end

    // The event input counts rising edges only, one tick each, so an event
    // pulse must stay high and low for at least two clocks to be seen
    // reliably through the synchroniser.
    // Pick one count pulse per selected period.
    always_comb begin
        if (cks[2]) begin
            tick = ev_s2_r && !ev_s3_r;
        end else if (cks == CKS_DIV2) begin
            tick = div_r[0];
        end else if (cks == CKS_DIV4) begin
            tick = div_r[1:0] == 2'h3;
        end else if (cks == CKS_DIV8) begin
            tick = div_r == 3'h7;
        end else begin
            tick = 1'b1;
        end
    end

    // ****************************************************************
    // Compare and capture events.
    // ****************************************************************
    // Matches count only in a counting cycle so each value fires once.
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic [1:0] edge_sel;
            assign edge_sel = iosel_r[g*4 +: 2];
            assign match[g] = run && tick && !is_capture(iosel_r, g)
                && count_value_r == gr_r[g];
            assign cap_ev[g] = is_capture(iosel_r, g) && (
                (edge_sel[0] && cap_rise[g]) ||
                (edge_sel[1] && cap_fall[g]));
        end
    endgenerate
    // A buffer register raises no events of its own.
    assign chan_ev = (match | cap_ev) & ~{bufb, bufa, 2'b00};
    // Overflow is the wrap from all ones; a clear on match A is no wrap.
    assign ovf_ev = run && tick && count_value_r == 16'hffff
        && !(clr_on_a && match[0]);

    // ****************************************************************
    // Counter.
    // ****************************************************************
    // A bus write to the counter beats a tick in the same cycle, so the
    // written value is never lost to an increment.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_value_r <= 16'h0000;
        end else if (wr_en && paddr_in == COUNT_OFF) begin
            count_value_r <= pwdata_in[15:0];
        end else if (run && tick) begin
            if (clr_on_a && match[0]) begin
                count_value_r <= 16'h0000;
            end else begin
                count_value_r <= count_value_r + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // General registers with buffer pairing.
    // ****************************************************************
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_gr
            if (g < 2) begin : g_live
                // A capture always loads the counter; in buffer mode the
                // partner takes the old value in the same clock.
                always_ff @(posedge sys_clk_in or negedge nrst_in) begin
                    if (!nrst_in) begin
                        gr_r[g] <= GR_RESET;
                    end else if (cap_ev[g]) begin
                        gr_r[g] <= count_value_r;
                    end else if (mode_r[MODE_BUFA_BIT + g] && match[g]) begin
                        gr_r[g] <= gr_r[g+2];
                    end else if (wr_en && paddr_in == GRA_OFF + 8'(g*4)) begin
                        gr_r[g] <= pwdata_in[15:0];
                    end
                end
            end else begin : g_pair
                // Registers C and D follow their partner on a buffered capture.
                always_ff @(posedge sys_clk_in or negedge nrst_in) begin
                    if (!nrst_in) begin
                        gr_r[g] <= GR_RESET;
                    end else if (mode_r[MODE_BUFA_BIT + g - 2]
                            && cap_ev[g-2]) begin
                        gr_r[g] <= gr_r[g-2];
                    end else if (cap_ev[g]) begin
                        gr_r[g] <= count_value_r;
                    end else if (wr_en && paddr_in == GRA_OFF + 8'(g*4)) begin
                        gr_r[g] <= pwdata_in[15:0];
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Pin drivers: compare action or PWM, preset by control writes.
    // ****************************************************************
    // A preset write beats a match in the same cycle. The output enable
    // follows the capture selection one clock later, so a channel turned
    // to capture still drives its pin for that one clock.
    // PWM on a channel sets at its own match and clears at match A.
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_pin
            fcct_action_type act;
            assign act = fcct_action_type'(iosel_r[g*4 +: 2]);
            always_ff @(posedge sys_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    pin_r[g] <= 1'b0;
                    oe_r[g] <= 1'b0;
                end else begin
                    oe_r[g] <= !is_capture(iosel_r, g);
                    if (wr_en && paddr_in == CTRL_OFF) begin
                        pin_r[g] <= pwdata_in[g];
                    end else if (pwm_sel[g] && match[g]) begin
                        pin_r[g] <= 1'b1;
                    end else if (pwm_sel[g] && match[0]) begin
                        pin_r[g] <= 1'b0;
                    end else if (!pwm_sel[g] && match[g]) begin
                        case (act)
                            FCCT_OUT_LOW: pin_r[g] <= 1'b0;
                            FCCT_OUT_HIGH: pin_r[g] <= 1'b1;
                            FCCT_OUT_TOGGLE: pin_r[g] <= !pin_r[g];
                            default: pin_r[g] <= pin_r[g];
                        endcase
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Control registers.
    // ****************************************************************
    // Reserved mode bits are never stored; they are forced on at readback.
    // Unmapped addresses decode to nothing, so a refused write is lost.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_r <= MODE_RESET;
            ctrl_r <= CTRL_RESET;
            iosel_r <= IOSEL_RESET;
            mask_r <= 5'h00;
        end else if (wr_en) begin
            if (paddr_in == MODE_OFF) begin
                mode_r <= pwdata_in[7:0] & MODE_WR_MASK;
            end else if (paddr_in == CTRL_OFF) begin
                ctrl_r <= pwdata_in[15:0];
            end else if (paddr_in == IOSEL_OFF) begin
                iosel_r <= pwdata_in[15:0];
            end else if (paddr_in == MASK_OFF) begin
                mask_r <= pwdata_in[4:0];
            end
        end
    end

    // ****************************************************************
    // Interrupt status: new events win over a write-one clear.
    // ****************************************************************
    // The interrupt line lags the status by one clock; it stays a clean
    // flip-flop output at the cost of that cycle of latency.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stat_r <= 5'h00;
            irq_r <= 1'b0;
        end else begin
            if (wr_en && paddr_in == STAT_OFF) begin
                stat_r <= (stat_r & ~pwdata_in[4:0]) | {ovf_ev, chan_ev};
            end else begin
                stat_r <= stat_r | {ovf_ev, chan_ev};
            end
            irq_r <= |(stat_r & mask_r);
        end
    end

    // ****************************************************************
    // APB slave: no wait states, addresses above GRD_OFF give an error.
    // ****************************************************************
    // Ready follows every setup phase by exactly one clock, so a master
    // that inserts no extra cycles sees the answer in its first access
    // cycle. Read data is sampled in setup and stands for that cycle.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= psel_in && !penable_in;
            pslverr_r <= psel_in && !penable_in && paddr_in > GRD_OFF;
            if (rd_en) begin
                if (paddr_in == MODE_OFF) begin
                    prdata_r <= {24'h0, mode_r | MODE_RSVD_ONES};
                end else if (paddr_in == CTRL_OFF) begin
                    prdata_r <= {16'h0, ctrl_r[15:4], pin_r};
                end else if (paddr_in == IOSEL_OFF) begin
                    prdata_r <= {16'h0, iosel_r};
                end else if (paddr_in == STAT_OFF) begin
                    prdata_r <= {27'h0, stat_r};
                end else if (paddr_in == MASK_OFF) begin
                    prdata_r <= {27'h0, mask_r};
                end else if (paddr_in == COUNT_OFF) begin
                    prdata_r <= {16'h0, count_value_r};
                end else if (paddr_in >= GRA_OFF && paddr_in <= GRD_OFF) begin
                    prdata_r <= {16'h0, gr_r[paddr_in[3:2] - 2'h2]};
                end else begin
                    prdata_r <= 32'h0000_0000;
                end
            end
        end
    end

    // Every output is a flip-flop; nothing combinational reaches a pin or
    // the bus.
    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign chan_pin_out = pin_r;
    assign chan_pin_oe_out = oe_r;
    assign irq_out = irq_r;

endmodule : fcct_timer

// File: tb/fcct_properties.sv
`timescale 1ns/10ps
module fcct_properties
    import fcct_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [3:0] chan_pin_oe_out,
    input wire logic irq_out
);
    // ****************************************************************
    // Shadows of what software wrote, and the properties.
    // ****************************************************************
    logic [7:0] mode_r;
    logic [15:0] iosel_r;
    logic [4:0] mask_r;
    logic setup;
    logic wr_ok;
    logic [3:0] cap;
    assign setup = psel_in && !penable_in;
    assign wr_ok = psel_in && penable_in && pready_out && pwrite_in;
    assign cap = {iosel_r[15], iosel_r[11], iosel_r[7], iosel_r[3]};
    // Mirrors only bus writes, so a lost or misplaced write shows up.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_r <= MODE_RESET;
            iosel_r <= IOSEL_RESET;
            mask_r <= 5'h00;
        end else if (wr_ok) begin
            if (paddr_in == MODE_OFF) mode_r <= pwdata_in[7:0] & MODE_WR_MASK;
            if (paddr_in == IOSEL_OFF) iosel_r <= pwdata_in[15:0];
            if (paddr_in == MASK_OFF) mask_r <= pwdata_in[4:0];
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    a_ready_next: assert property (setup |=> pready_out)
        else $error("pready missing after setup");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready held too long");
    a_err_high: assert property (setup && paddr_in > GRD_OFF |=> pslverr_out)
        else $error("unmapped address not refused");
    a_err_low: assert property (setup && paddr_in <= GRD_OFF |=> !pslverr_out)
        else $error("mapped address refused");
    a_bad_read_zero: assert property (setup && !pwrite_in &&
        paddr_in > GRD_OFF |=> prdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_mode_read: assert property (
        setup && !pwrite_in && paddr_in == MODE_OFF |=>
        prdata_out == {24'h0, mode_r | MODE_RSVD_ONES})
        else $error("mode readback wrong");
    a_irq_masked: assert property (
        mask_r == 5'h00 && $past(mask_r) == 5'h00 |-> !irq_out)
        else $error("interrupt while fully masked");
    a_capture_quiet: assert property (
        (cap & $past(cap) & chan_pin_oe_out) == 4'h0)
        else $error("capture pin driven");
    c_mode_read: cover property (setup && paddr_in == MODE_OFF);
    c_irq_rise: cover property ($rose(irq_out));
    c_refused: cover property (pslverr_out);
endmodule : fcct_properties
bind fcct_timer fcct_properties fcct_properties_i (.sys_clk_in, .nrst_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .chan_pin_oe_out, .irq_out);

// File: tb/fcct_pins_model.sv
`timescale 1ns/10ps
module fcct_pins_model (
    input wire logic sys_clk_in,
    input wire logic [3:0] chan_pin_out_in,
    input wire logic [3:0] chan_pin_oe_in,
    input wire logic [3:0] drive_lvl_in,
    output logic event_clock_out,
    output logic [3:0] chan_pin_level_out
);
    // The timer wins where it drives; elsewhere the outside source does.
    assign chan_pin_level_out = (chan_pin_oe_in & chan_pin_out_in) |
        (~chan_pin_oe_in & drive_lvl_in);
    initial event_clock_out = 1'b0;
    // Event pulses of two cycles high, two low; the line rests low.
    task automatic pulse(input int n);
        repeat (n) begin
            event_clock_out <= 1'b1;
            repeat (2) @(posedge sys_clk_in);
            event_clock_out <= 1'b0;
            repeat (2) @(posedge sys_clk_in);
        end
    endtask : pulse
endmodule : fcct_pins_model

// File: tb/fcct_timer_test.sv
`timescale 1ns/10ps
module fcct_timer_test import fcct_pkg::*;;
    // ****************************************************************
    // Bench signals, design and pin model.
    // ****************************************************************
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q, k2;
    logic pready, pslverr, ev, irq, e;
    logic [3:0] pin_in, pin_out, pin_oe;
    logic [3:0] pin_drv = 4'h0;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    fcct_timer fcct_timer_i (.sys_clk_in(clk), .nrst_in(nrst),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .event_clock_in(ev),
        .chan_pin_in(pin_in), .chan_pin_out(pin_out),
        .chan_pin_oe_out(pin_oe), .irq_out(irq));
    fcct_pins_model fcct_pins_model_i (.sys_clk_in(clk),
        .chan_pin_out_in(pin_out), .chan_pin_oe_in(pin_oe),
        .drive_lvl_in(pin_drv), .event_clock_out(ev),
        .chan_pin_level_out(pin_in));
    // Comparisons; a mismatch is reported at once.
    task automatic cmp_word(input logic [31:0] g, x);
        checks++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask : cmp_word
    task automatic cmp_bits(input logic [3:0] g, x);
        checks++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask : cmp_bits
    // One bus transfer; the extra edge keeps psel low between transfers.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        if (n == 40) error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // Mode reset value, writable bits, general register reset, refusal.
    task automatic t_regs();
        apb(1'b0, MODE_OFF, 32'h0);
        cmp_word(q, 32'h48);
        wr(MODE_OFF, 32'hff);
        apb(1'b0, MODE_OFF, 32'h0);
        cmp_word(q, 32'hff);
        wr(MODE_OFF, 32'h35);
        apb(1'b0, MODE_OFF, 32'h0);
        cmp_word(q, 32'h7d);
        wr(MODE_OFF, 32'h0);
        apb(1'b0, GRA_OFF, 32'h0);
        cmp_word(q, 32'hffff);
        apb(1'b0, 8'h28, 32'h0);
        cmp_bits({3'h0, e}, 4'h1);
    endtask : t_regs
    // Presets reach the pins before any match.
    task automatic t_preset();
        wr(IOSEL_OFF, 32'h0);
        wr(CTRL_OFF, 32'h0c);
        cmp_bits(pin_out, 4'hc);
        cmp_bits(pin_oe, 4'hf);
    endtask : t_preset
    // Toggle, high, low and hold actions with clearing on match A.
    task automatic t_compare();
        wr(GRA_OFF, 32'h9);
        wr(GRB_OFF, 32'h4);
        wr(GRC_OFF, 32'h4);
        wr(GRD_OFF, 32'h4);
        wr(IOSEL_OFF, 32'h0123);
        wr(COUNT_OFF, 32'h0);
        wr(CTRL_OFF, 32'h8c);
        wr(MODE_OFF, 32'h80);
        repeat (30) @(posedge clk);
        wr(MODE_OFF, 32'h0);
        cmp_bits(pin_out & 4'he, 4'ha);
        apb(1'b0, COUNT_OFF, 32'h0);
        cmp_bits({3'h0, q[15:0] <= 16'h9}, 4'h1);
        apb(1'b0, STAT_OFF, 32'h0);
        cmp_bits(q[3:0], 4'hf);
        wr(STAT_OFF, 32'h1f);
    endtask : t_compare
    // Each divide ratio over 64 cycles, then the event input.
    task automatic t_clock();
        for (int k = 0; k < 4; k++) begin
            wr(COUNT_OFF, 32'h0);
            wr(CTRL_OFF, 32'(k) << CTRL_CKS_LSB);
            wr(MODE_OFF, 32'h80);
            repeat (62) @(posedge clk);
            wr(MODE_OFF, 32'h0);
            apb(1'b0, COUNT_OFF, 32'h0);
            k2 = 32'd64 >> k;
            cmp_bits({3'h0, q + 1 >= k2 && q <= k2 + 1}, 4'h1);
        end
        repeat (10) @(posedge clk);
        k2 = q;
        apb(1'b0, COUNT_OFF, 32'h0);
        cmp_word(q, k2);
        wr(COUNT_OFF, 32'h0);
        wr(CTRL_OFF, 32'h40);
        wr(MODE_OFF, 32'h80);
        fcct_pins_model_i.pulse(10);
        repeat (4) @(posedge clk);
        wr(MODE_OFF, 32'h0);
        apb(1'b0, COUNT_OFF, 32'h0);
        cmp_word(q, 32'ha);
    endtask : t_clock
    // Wrap sets overflow, the unmasked flag raises irq, a one clears it.
    task automatic t_ovf();
        int n;
        n = 0;
        wr(STAT_OFF, 32'h1f);
        wr(MASK_OFF, 32'h10);
        wr(COUNT_OFF, 32'hfffe);
        wr(CTRL_OFF, 32'h0);
        wr(MODE_OFF, 32'h80);
        while (irq !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        wr(MODE_OFF, 32'h0);
        cmp_bits({3'h0, irq}, 4'h1);
        apb(1'b0, COUNT_OFF, 32'h0);
        cmp_bits({3'h0, q[15:0] < 16'h20}, 4'h1);
        wr(STAT_OFF, 32'h10);
        repeat (2) @(posedge clk);
        cmp_bits({3'h0, irq}, 4'h0);
        wr(MASK_OFF, 32'h0);
    endtask : t_ovf
    // PWM on B, C and D rises at their own match and falls at match A.
    task automatic t_pwm();
        wr(GRA_OFF, 32'h9);
        wr(GRB_OFF, 32'h4);
        wr(GRC_OFF, 32'h4);
        wr(GRD_OFF, 32'h4);
        wr(IOSEL_OFF, 32'h0);
        wr(CTRL_OFF, 32'h01);
        wr(COUNT_OFF, 32'h3);
        wr(MODE_OFF, 32'h87);
        wr(MODE_OFF, 32'h07);
        cmp_bits(pin_out, 4'hf);
        wr(MODE_OFF, 32'h87);
        repeat (8) @(posedge clk);
        wr(MODE_OFF, 32'h07);
        cmp_bits(pin_out, 4'h1);
    endtask : t_pwm
    // Buffered capture on A moves the old value into C.
    task automatic t_capture();
        wr(MODE_OFF, 32'h10);
        wr(IOSEL_OFF, 32'h0009);
        wr(COUNT_OFF, 32'h1234);
        pin_drv <= 4'h1;
        repeat (6) @(posedge clk);
        cmp_bits(pin_oe & 4'h1, 4'h0);
        apb(1'b0, GRA_OFF, 32'h0);
        cmp_word(q, 32'h1234);
        apb(1'b0, GRC_OFF, 32'h0);
        cmp_word(q, 32'h9);
    endtask : t_capture
    // Verdict; the only place the run ends.
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // Cuts a hang short well beyond the few hundred cycles needed.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_regs();
        t_preset();
        t_compare();
        t_clock();
        t_ovf();
        t_pwm();
        t_capture();
        end_of_test();
    end
endmodule : fcct_timer_test
